// File: core/rgo_rail_group_oc.sv
// rail group and overcurrent response registers with their fault behaviour
//
// Functional notes
// RULE_01: three group id and enable pairs
// RULE_02: group ids never compared with rail id
// RULE_03: broadcasts act only on matching enabled group
// RULE_04: current sharing needs no fault group match
// RULE_05: rail faults spread to current-sharing peers
// RULE_06: grouped or sequenced devices never auto-retry
// RULE_07: own messages sent even with enables off
// RULE_08: group zero is a valid group
// RULE_09: field positions of the rail group register
// RULE_10: overcurrent sets status flag and alert
// RULE_11: code 10 disables at once, then retries
// RULE_12: retry 000 latches off, 111 retries
// RULE_13: retry interval is (code+1) times 35 ms
// RULE_14: sequencing alone does not spread faults
`timescale 1ns/100ps
module rgo_rail_group_oc #(
  parameter int RETRY_UNIT_CYC = rgo_pkg::RETRY_UNIT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  // decoded management-bus command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  input wire logic clear_faults,
  output logic rsp_valid_r,
  output logic rsp_err_r,
  output logic [31:0] rsp_rdata_r,
  // device context
  input wire logic [4:0] own_rail_id,
  input wire logic cs_member,
  input wire logic seq_member,
  // pins from outside the clock domain
  input wire logic oc_fault_pin,
  input wire logic op_on_pin,
  input wire logic bias_ok_pin,
  // inter-module bus, decoded messages
  input wire logic rx_valid,
  input wire rgo_pkg::rgo_msg_s rx_msg,
  output logic tx_valid_r,
  output rgo_pkg::rgo_msg_s tx_msg_r,
  // effects
  output logic op_apply_r,
  output logic vout_apply_r,
  output logic [15:0] apply_data_r,
  output logic out_enable_r,
  output logic oc_flag_r,
  output logic alert_output_r
);
  logic [31:0] rail_group_r; // rail_group_config
  logic [7:0] oc_resp_r; // overcurrent_response_config
  logic [2:0] sync_a_r; // first synchroniser stage
  logic [2:0] sync_b_r; // second stage, the only one read
  logic oc_s, op_on_s, bias_ok_s; // synchronised levels
  rgo_pkg::rgo_state_e st_r, st_nxt;
  logic fault_evt; // new overcurrent while running
  logic grp_fault_hit; // fault message for our enabled group
  logic rail_fault_hit; // fault from our own current-sharing rail
  logic other_fault; // spread faults force shutdown
  logic grouped; // member of fault-spreading or sequencing group
  logic may_retry;
  logic retry_start, retry_done;
  logic rail_tx_pend_r; // rail fault message still to send

  // field views
  wire [4:0] vout_gid = rail_group_r[rgo_pkg::VOUT_GID_LSB +: rgo_pkg::GID_W]; // RULE_09
  wire vout_en = rail_group_r[rgo_pkg::VOUT_EN_BIT]; // RULE_09
  wire [4:0] op_gid = rail_group_r[rgo_pkg::OP_GID_LSB +: rgo_pkg::GID_W]; // RULE_09
  wire op_en = rail_group_r[rgo_pkg::OP_EN_BIT]; // RULE_09
  wire [4:0] flt_gid = rail_group_r[rgo_pkg::FLT_GID_LSB +: rgo_pkg::GID_W]; // RULE_09
  wire flt_en = rail_group_r[rgo_pkg::FLT_EN_BIT]; // RULE_09
  wire [1:0] resp_code = oc_resp_r[rgo_pkg::CODE_LSB +: 2];
  wire [2:0] retry_mode = oc_resp_r[rgo_pkg::RETRY_LSB +: 3];
  wire [2:0] retry_delay = oc_resp_r[rgo_pkg::DELAY_LSB +: 3];

  // group match: enable set and ids equal; zero is an ordinary id
  function automatic logic grp_hit(input logic en, input logic [4:0] mine, input logic [4:0] theirs);
    grp_hit = en && (mine == theirs); // RULE_03 RULE_08
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_a_r <= '0;
      sync_b_r <= '0;
    end else begin
      sync_a_r <= {oc_fault_pin, op_on_pin, bias_ok_pin};
      sync_b_r <= sync_a_r;
    end
  end
  assign oc_s = sync_b_r[2];
  assign op_on_s = sync_b_r[1];
  assign bias_ok_s = sync_b_r[0];

  ////////////////////////////////////////////////////////////////////
  // register writes; reserved bits are dropped so they read as zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rail_group_r <= rgo_pkg::RAIL_GROUP_RST;
      oc_resp_r <= rgo_pkg::OC_RESP_RST;
    end else if (cmd_valid && cmd_write) begin
      if (cmd_code == rgo_pkg::CMD_RAIL_GROUP) begin
        rail_group_r <= cmd_wdata & rgo_pkg::RAIL_GROUP_MASK; // RULE_01 RULE_09
      end
      if (cmd_code == rgo_pkg::CMD_OC_RESP) begin
        oc_resp_r <= cmd_wdata[7:0];
      end
    end
  end

  // command answer one cycle after the request; unknown codes flag an error
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_rdata_r <= '0;
    end else begin
      rsp_valid_r <= cmd_valid;
      rsp_err_r <= 1'b0;
      rsp_rdata_r <= '0;
      if (cmd_valid) begin
        case (cmd_code)
          rgo_pkg::CMD_RAIL_GROUP: rsp_rdata_r <= rail_group_r;
          rgo_pkg::CMD_OC_RESP: rsp_rdata_r <= {24'h00_0000, oc_resp_r};
          default: rsp_err_r <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // incoming message decode
  // rail faults are matched on the rail id only, fault groups on group id only
  assign grp_fault_hit = rx_valid && rx_msg.kind == rgo_pkg::MSG_FAULT_GRP
                         && grp_hit(flt_en, flt_gid, rx_msg.gid); // RULE_02
  assign rail_fault_hit = rx_valid && rx_msg.kind == rgo_pkg::MSG_RAIL_FAULT
                          && cs_member && rx_msg.src_id == own_rail_id; // RULE_02 RULE_04 RULE_05
  assign other_fault = grp_fault_hit || rail_fault_hit;

  // broadcast operation and output-voltage commands
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      op_apply_r <= 1'b0;
      vout_apply_r <= 1'b0;
      apply_data_r <= '0;
    end else begin
      op_apply_r <= rx_valid && rx_msg.kind == rgo_pkg::MSG_OP_GRP
                    && grp_hit(op_en, op_gid, rx_msg.gid); // RULE_03
      vout_apply_r <= rx_valid && rx_msg.kind == rgo_pkg::MSG_VOUT_GRP
                      && grp_hit(vout_en, vout_gid, rx_msg.gid); // RULE_03
      if (rx_valid) begin
        apply_data_r <= rx_msg.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // protection state machine
  // a device in a fault group or a sequencing group never restarts on its own
  assign grouped = flt_en || seq_member; // RULE_06
  assign may_retry = retry_mode == rgo_pkg::RETRY_FOREVER && !grouped; // RULE_06 RULE_12
  assign fault_evt = st_r == rgo_pkg::RG_RUN && oc_s && op_on_s;
  assign retry_start = fault_evt && resp_code == rgo_pkg::CODE_DISABLE && may_retry;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      rgo_pkg::RG_RUN: begin
        if (other_fault) begin
          st_nxt = rgo_pkg::RG_LATCHED; // RULE_05
        end else if (retry_start) begin
          st_nxt = rgo_pkg::RG_WAIT; // RULE_11
        end else if (fault_evt) begin
          // no retry, and unused codes, stay off until cleared
          st_nxt = rgo_pkg::RG_LATCHED; // RULE_12
        end
      end
      rgo_pkg::RG_WAIT: begin
        if (other_fault || !bias_ok_s || grouped) begin
          st_nxt = rgo_pkg::RG_LATCHED; // RULE_12
        end else if (!op_on_s) begin
          st_nxt = rgo_pkg::RG_RUN; // commanded off ends retrying
        end else if (retry_done) begin
          st_nxt = rgo_pkg::RG_RUN; // RULE_12
        end
      end
      rgo_pkg::RG_LATCHED: begin
        if (clear_faults && !oc_s) begin
          st_nxt = rgo_pkg::RG_RUN;
        end
      end
      default: st_nxt = rgo_pkg::RG_LATCHED;
    endcase
  end

  // state and output enable; the output drops in the cycle after the event
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= rgo_pkg::RG_RUN;
      out_enable_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      out_enable_r <= st_nxt == rgo_pkg::RG_RUN && op_on_s && bias_ok_s && !fault_evt; // RULE_11
    end
  end

  rgo_retry_timer #(
    .UNIT_CYC(RETRY_UNIT_CYC)
  ) u_timer (
    .mclk(mclk),
    .resetn(resetn),
    .start(retry_start),
    .run(st_r == rgo_pkg::RG_WAIT),
    .delay_code(retry_delay),
    .done_r(retry_done)
  );

  ////////////////////////////////////////////////////////////////////
  // status flag and alert; a new fault wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      oc_flag_r <= 1'b0;
      alert_output_r <= 1'b0;
    end else if (fault_evt) begin
      oc_flag_r <= 1'b1; // RULE_10
      alert_output_r <= 1'b1; // RULE_10
    end else if (clear_faults) begin
      oc_flag_r <= 1'b0;
      alert_output_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outgoing messages: group fault always, rail fault only for current sharing;
  // sequencing partners get nothing directly
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_valid_r <= 1'b0;
      tx_msg_r <= '0;
      rail_tx_pend_r <= 1'b0;
    end else begin
      tx_valid_r <= 1'b0;
      if (fault_evt) begin
        tx_valid_r <= 1'b1; // RULE_07 RULE_08
        tx_msg_r <= '{kind: rgo_pkg::MSG_FAULT_GRP, gid: flt_gid, src_id: own_rail_id, data: 16'h0000};
        rail_tx_pend_r <= cs_member; // RULE_05 RULE_14
      end else if (rail_tx_pend_r) begin
        tx_valid_r <= 1'b1;
        tx_msg_r <= '{kind: rgo_pkg::MSG_RAIL_FAULT, gid: 5'h00, src_id: own_rail_id, data: 16'h0000};
        rail_tx_pend_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  rail_fields_a: assert property (cmd_valid && cmd_write && cmd_code == rgo_pkg::CMD_RAIL_GROUP // RULE_09
      |=> rail_group_r == ($past(cmd_wdata) & rgo_pkg::RAIL_GROUP_MASK) && rail_group_r[31:22] == '0)
    else $error("rail group write not stored in its fields");
  group_pairs_a: assert property (rx_valid && rx_msg.kind == rgo_pkg::MSG_VOUT_GRP && vout_en // RULE_01
      && rx_msg.gid == vout_gid |=> vout_apply_r && !op_apply_r)
    else $error("output-voltage pair did not act alone");
  rail_id_sep_a: assert property (rx_valid && rx_msg.kind == rgo_pkg::MSG_RAIL_FAULT // RULE_02
      && rx_msg.src_id != own_rail_id && st_r == rgo_pkg::RG_RUN && !fault_evt |=> st_r == rgo_pkg::RG_RUN)
    else $error("rail fault from a foreign rail acted on");
  op_match_a: assert property (op_apply_r |-> $past(op_en) && $past(rx_msg.gid) == $past(op_gid)) // RULE_03
    else $error("operation applied without group match");
  cs_spread_a: assert property (st_r == rgo_pkg::RG_RUN && rail_fault_hit && !flt_en // RULE_04
      |=> st_r == rgo_pkg::RG_LATCHED ##1 !out_enable_r) // RULE_05
    else $error("current-sharing fault not spread");
  no_retry_a: assert property (st_r == rgo_pkg::RG_WAIT |-> !grouped || $past(!grouped)) // RULE_06
    else $error("grouped device waiting to retry");
  own_tx_a: assert property (fault_evt && !other_fault |=> tx_valid_r // RULE_07
      && tx_msg_r.kind == rgo_pkg::MSG_FAULT_GRP && tx_msg_r.gid == $past(flt_gid)) // RULE_08
    else $error("own fault message not sent");
  oc_flag_a: assert property (fault_evt |=> oc_flag_r && alert_output_r) // RULE_10
    else $error("overcurrent flag or alert missing");
  oc_disable_a: assert property (fault_evt |=> !out_enable_r [*2]) // RULE_11
    else $error("output not disabled at once");
  latch_hold_a: assert property (st_r == rgo_pkg::RG_LATCHED && !clear_faults |=> st_r == rgo_pkg::RG_LATCHED) // RULE_12
    else $error("latched fault released without clear");
  seq_no_spread_a: assert property (tx_valid_r && tx_msg_r.kind == rgo_pkg::MSG_RAIL_FAULT |-> cs_member) // RULE_14
    else $error("rail fault sent without current sharing");
  // the rail message trails the group message by one cycle, so peers see both
  rail_tx_a: assert property (fault_evt && cs_member |=> ##1 tx_valid_r // RULE_05
      && tx_msg_r.kind == rgo_pkg::MSG_RAIL_FAULT && tx_msg_r.src_id == own_rail_id)
    else $error("rail fault not sent after own fault");

  // main scenarios the bench is expected to reach
  retry_cycle_c: cover property (st_r == rgo_pkg::RG_WAIT ##1 st_r == rgo_pkg::RG_RUN);
  latch_clear_c: cover property (st_r == rgo_pkg::RG_LATCHED ##1 st_r == rgo_pkg::RG_RUN);
  vout_apply_c: cover property (vout_apply_r);
  rail_tx_c: cover property (tx_valid_r && tx_msg_r.kind == rgo_pkg::MSG_RAIL_FAULT);
  cs_spread_c: cover property (rail_fault_hit && st_r == rgo_pkg::RG_RUN);
endmodule // rgo_rail_group_oc

// File: core/rgo_pkg.sv
// package: command codes, field layout, reset values, timing and message types
package rgo_pkg;
  // command codes of the two registers
  localparam logic [7:0] CMD_RAIL_GROUP = 8'hE2;
  localparam logic [7:0] CMD_OC_RESP = 8'hE5;
  // rail_group_config field positions
  localparam int VOUT_GID_LSB = 16;
  localparam int VOUT_EN_BIT = 21;
  localparam int OP_GID_LSB = 8;
  localparam int OP_EN_BIT = 13;
  localparam int FLT_GID_LSB = 0;
  localparam int FLT_EN_BIT = 5;
  localparam int GID_W = 5;
  // writable bits of rail_group_config, the rest read as zero
  localparam logic [31:0] RAIL_GROUP_MASK = 32'h003F_3F3F;
  localparam logic [31:0] RAIL_GROUP_RST = 32'h0000_0000;
  // overcurrent_response_config fields
  localparam int CODE_LSB = 6;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_LSB = 0;
  localparam logic [7:0] OC_RESP_RST = 8'hB8;
  localparam logic [1:0] CODE_DISABLE = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // retry delay unit: 35 ms at a 10 ns clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int RETRY_UNIT_MS = 35;
  localparam int RETRY_UNIT_CYC = (RETRY_UNIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int UNIT_CNT_W = 22;
  // inter-module bus message kinds
  typedef enum logic [1:0] {
    MSG_FAULT_GRP,
    MSG_OP_GRP,
    MSG_VOUT_GRP,
    MSG_RAIL_FAULT
  } rgo_msg_kind_e;
  // one inter-module bus message
  typedef struct packed {
    rgo_msg_kind_e kind;
    logic [4:0] gid;
    logic [4:0] src_id;
    logic [15:0] data;
  } rgo_msg_s;
  // protection state
  typedef enum logic [1:0] {
    RG_RUN,
    RG_WAIT,
    RG_LATCHED
  } rgo_state_e;
endpackage

// File: core/rgo_retry_timer.sv
// retry interval timer: (code + 1) units of one retry period
`timescale 1ns/100ps
module rgo_retry_timer #(
  parameter int UNIT_CYC = rgo_pkg::RETRY_UNIT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic start,
  input wire logic run,
  input wire logic [2:0] delay_code,
  output logic done_r
);
  logic [rgo_pkg::UNIT_CNT_W-1:0] unit_cnt_r; // cycles within one unit
  logic [3:0] units_left_r; // units still to wait
  logic tick; // one-cycle enable at each unit end

  assign tick = run && (unit_cnt_r == rgo_pkg::UNIT_CNT_W'(UNIT_CYC - 1));

  ////////////////////////////////////////////////////////////////////
  // unit divider, restarted by start so the first unit is full length
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      unit_cnt_r <= '0;
    end else if (start || !run || tick) begin
      unit_cnt_r <= '0;
    end else begin
      unit_cnt_r <= unit_cnt_r + 1'b1;
    end
  end

  // unit counter loaded with code plus one
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      units_left_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        units_left_r <= {1'b0, delay_code} + 4'h1; // RULE_13
      end else if (tick && units_left_r != 4'h0) begin
        units_left_r <= units_left_r - 4'h1;
        done_r <= (units_left_r == 4'h1);
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // a unit ends exactly when the divider reaches its top count
  unit_wrap_a: assert property (tick |=> unit_cnt_r == '0) // RULE_13
    else $error("retry unit divider did not wrap");
  // done only comes on the last unit tick
  done_cause_a: assert property (done_r |-> $past(tick) && $past(units_left_r) == 4'h1) // RULE_13
    else $error("retry done without final unit");
endmodule // rgo_retry_timer

// File: bench/rgo_peer_model.sv
// peer module model: drives decoded inter-module bus messages into the block
`timescale 1ns/100ps
module rgo_peer_model (
  input wire logic mclk,
  output logic rx_valid,
  output rgo_pkg::rgo_msg_s rx_msg
);
  // quiet bus at time zero
  initial begin
    rx_valid = 1'b0;
    rx_msg = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one message per call, a single cycle strobe launched at the falling edge
  task automatic send(input rgo_pkg::rgo_msg_kind_e kind, input logic [4:0] gid,
    input logic [4:0] src, input logic [15:0] data);
    @(negedge mclk);
    rx_msg = '{kind: kind, gid: gid, src_id: src, data: data};
    rx_valid = 1'b1;
    @(negedge mclk);
    rx_valid = 1'b0;
    // released bus never repeats the stale message
    rx_msg = ~rx_msg;
  endtask
endmodule // rgo_peer_model

// File: bench/rgo_rail_group_oc_tb.sv
// self-checking bench for the rail group and overcurrent response block
`timescale 1ns/100ps
module rgo_rail_group_oc_tb;
  localparam int UNIT = 10; // short retry unit keeps the run brief
  logic mclk, resetn, cmd_valid, cmd_write, clear_faults, cs_member, seq_member, rx_valid;
  logic oc_fault_pin, op_on_pin, bias_ok_pin, rsp_valid_r, rsp_err_r, tx_valid_r;
  logic op_apply_r, vout_apply_r, out_enable_r, oc_flag_r, alert_output_r;
  logic [7:0] cmd_code;
  logic [31:0] cmd_wdata, rsp_rdata_r, rd, cfg;
  logic [15:0] apply_data_r;
  logic [4:0] own_rail_id;
  rgo_pkg::rgo_msg_s rx_msg, tx_msg_r;
  int bad_count, checks;
  rgo_rail_group_oc #(.RETRY_UNIT_CYC(UNIT)) i_rgo_rail_group_oc (.mclk, .resetn, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_wdata, .clear_faults, .rsp_valid_r, .rsp_err_r, .rsp_rdata_r, .own_rail_id, .cs_member,
    .seq_member, .oc_fault_pin, .op_on_pin, .bias_ok_pin, .rx_valid, .rx_msg, .tx_valid_r, .tx_msg_r,
    .op_apply_r, .vout_apply_r, .apply_data_r, .out_enable_r, .oc_flag_r, .alert_output_r);
  rgo_peer_model i_rgo_peer_model (.mclk, .rx_valid, .rx_msg);
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog, the limit is well past the longest expected run
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #500_000;
    bad_count++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // compare, count, report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // expected broadcast response: enable set and group equal, rail id plays no part
  function automatic logic exp_apply(input logic [31:0] c, input logic vout, input logic [4:0] g);
    return vout ? (c[21] && c[20:16] == g) : (c[13] && c[12:8] == g);
  endfunction
  // one command; the answer stands for one cycle, so take it before dropping the request
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [31:0] wd);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wd;
    @(negedge mclk);
    rd = rsp_err_r ? 32'hFFFF_FFFF : rsp_rdata_r;
    chk("rsp_valid", 1, rsp_valid_r);
    cmd_valid = 1'b0;
    cmd_wdata = ~wd;
  endtask
  // bounded wait for the power stage to come back
  task automatic wait_on(input int lim, output int n);
    n = 0;
    while (out_enable_r !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask
  // overcurrent pulse, wait for the outgoing fault message
  task automatic oc_hit();
    int n;
    n = 0;
    @(negedge mclk);
    oc_fault_pin = 1'b1;
    while (tx_valid_r !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    chk("tx_valid", 1, tx_valid_r);
    chk("tx_kind", rgo_pkg::MSG_FAULT_GRP, tx_msg_r.kind);
    chk("tx_src", own_rail_id, tx_msg_r.src_id);
    chk("tx_gid", cfg[4:0], tx_msg_r.gid);
    chk("out_enable", 0, out_enable_r);
    chk("oc_flag", 1, oc_flag_r);
    chk("alert", 1, alert_output_r);
    oc_fault_pin = 1'b0;
  endtask
  // clear faults with the comparator quiet
  task automatic clr();
    int n;
    @(negedge mclk);
    clear_faults = 1'b1;
    @(negedge mclk);
    clear_faults = 1'b0;
    wait_on(10, n);
    chk("flag_clear", 0, oc_flag_r);
    chk("alert_clear", 0, alert_output_r);
    chk("enable_back", 1, out_enable_r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] w;
    logic [15:0] d;
    logic [4:0] g;
    int n, ex;
    logic [7:0] e5 [4];
    logic [31:0] e2 [4];
    e5 = '{8'h80, 8'h3F, 8'hB8, 8'hB8};
    e2 = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0023, 32'h0000_0000};
    void'($urandom(32'h4a40_7bbc));
    {resetn, cmd_valid, cmd_write, clear_faults, cs_member, seq_member, oc_fault_pin} = '0;
    {op_on_pin, bias_ok_pin, cmd_code, cmd_wdata, cfg} = '0;
    own_rail_id = 5'h01;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    op_on_pin = 1'b1;
    bias_ok_pin = 1'b1;
    wait_on(10, n);
    // reset values and an unmapped code
    cmd(0, 8'hE2, 0);
    chk("rail_group_rst", 32'h0, rd);
    cmd(0, 8'hE5, 0);
    chk("oc_resp_rst", 32'h0000_00B8, rd);
    cmd(0, 8'hE3, 0);
    chk("unmapped", 32'hFFFF_FFFF, rd);
    // random write and read back, reserved bits drop out
    for (int i = 0; i < 6; i++) begin
      w = $urandom();
      cmd(1, 8'hE2, w);
      cmd(0, 8'hE2, 0);
      chk("rail_group_rd", w & 32'h003F_3F3F, rd);
      cmd(1, 8'hE5, w);
      cmd(0, 8'hE5, 0);
      chk("oc_resp_rd", {24'h0, w[7:0]}, rd);
    end
    // broadcasts, group zero first, then random enables and groups
    for (int i = 0; i < 16; i++) begin
      cfg = (i == 0) ? 32'h0020_2000 : ($urandom() & 32'h0023_2323);
      g = (i == 0) ? 5'h0 : 5'($urandom_range(3));
      d = 16'($urandom());
      cmd(1, 8'hE2, cfg);
      // the apply pulse stands only in the cycle after the message, look at it now
      i_rgo_peer_model.send(i % 2 ? rgo_pkg::MSG_VOUT_GRP : rgo_pkg::MSG_OP_GRP, g, 5'h01, d);
      chk("op_apply", exp_apply(cfg, i % 2, g) && i % 2 == 0, op_apply_r);
      chk("vout_apply", exp_apply(cfg, i % 2, g) && i % 2 == 1, vout_apply_r);
      if (exp_apply(cfg, i % 2, g)) begin
        chk("apply_data", d, apply_data_r);
      end
    end
    // retry interval with delay codes 0, 7 and one random
    cfg = 0;
    cmd(1, 8'hE2, 0);
    for (int k = 0; k < 3; k++) begin
      w = (k == 0) ? 0 : (k == 1) ? 7 : $urandom_range(6);
      cmd(1, 8'hE5, {5'b10111, w[2:0]});
      oc_hit();
      wait_on(9 * UNIT + 20, n);
      ex = (w[2:0] + 1) * UNIT;
      chk("retry_gap", 1, n >= ex && n <= ex + 6);
    end
    // latch-off cases: no retry, unused code, fault group member, sequenced member
    for (int k = 0; k < 4; k++) begin
      cfg = e2[k];
      seq_member = (k == 3);
      cmd(1, 8'hE2, cfg);
      cmd(1, 8'hE5, e5[k]);
      oc_hit();
      wait_on(8 * UNIT + 20, n);
      chk("stays_off", 0, out_enable_r);
      clr();
    end
    seq_member = 1'b0;
    // rail faults spread only inside a current-sharing rail
    cmd(1, 8'hE2, 0);
    cs_member = 1'b1;
    i_rgo_peer_model.send(rgo_pkg::MSG_RAIL_FAULT, 5'h09, 5'h02, 16'h0);
    repeat (3) @(negedge mclk);
    chk("other_rail", 1, out_enable_r);
    i_rgo_peer_model.send(rgo_pkg::MSG_RAIL_FAULT, 5'h09, 5'h01, 16'h0);
    repeat (3) @(negedge mclk);
    chk("cs_spread", 0, out_enable_r);
    clr();
    // own fault inside a current-sharing rail: group message, then rail message
    cmd(1, 8'hE5, 32'h0000_0080);
    oc_hit();
    @(negedge mclk);
    chk("rail_tx_valid", 1, tx_valid_r);
    chk("rail_tx_kind", rgo_pkg::MSG_RAIL_FAULT, tx_msg_r.kind);
    chk("rail_tx_src", own_rail_id, tx_msg_r.src_id);
    clr();
    cs_member = 1'b0;
    i_rgo_peer_model.send(rgo_pkg::MSG_RAIL_FAULT, 5'h09, 5'h01, 16'h0);
    repeat (3) @(negedge mclk);
    chk("no_cs", 1, out_enable_r);
    // fault group message with matching enabled group
    cmd(1, 8'hE2, 32'h0000_0024);
    i_rgo_peer_model.send(rgo_pkg::MSG_FAULT_GRP, 5'h04, 5'h03, 16'h0);
    repeat (3) @(negedge mclk);
    chk("group_fault", 0, out_enable_r);
    clr();
    close_out();
  end
endmodule // rgo_rail_group_oc_tb
